// ==== rtl/pscl_loader.sv ====
`timescale 1ns/1ns
`include "pscl_regs.svh"
module pscl_loader
  import pscl_pkg::*;
#(
  parameter int unsigned WORD_W         = `PSCL_WORD_W,
  parameter int unsigned BITSTREAM_BITS = `PSCL_BITSTREAM_BITS,
  parameter int unsigned OPT_INIT_BIT   = `PSCL_OPT_INIT_BIT,
  parameter int unsigned POR_CYCLES     = `PSCL_POR_US * `PSCL_CLK_MHZ,
  parameter int unsigned STATUS_CYCLES  = `PSCL_STATUS_US * `PSCL_CLK_MHZ,
  parameter int unsigned INIT_CYCLES    = `PSCL_INIT_US * `PSCL_CLK_MHZ,
  parameter bit          DATA_PIN_DRIVE = 1'b0
) (
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  // Configuration request pin, active low
  input  wire logic              cfg_req_n_in,
  // Status pin, open drain, active low
  input  wire logic              status_n_in,
  output      logic              status_n_out,
  output      logic              status_n_oe_out,
  // Load-complete pin, open drain
  input  wire logic              load_complete_in,
  output      logic              load_complete_out,
  output      logic              load_complete_oe_out,
  // Initialization-complete pin, open drain
  output      logic              init_done_out,
  output      logic              init_done_oe_out,
  // Serial link from the host
  input  wire logic              config_serial_clock_in,
  input  wire logic              config_serial_data_in,
  output      logic              config_serial_data_out,
  output      logic              config_serial_data_oe_out,
  // User side of the data pin after configuration
  input  wire logic              user_tx_in,
  output      logic              user_rx_out,
  output      logic              user_mode_out,
  // Loaded configuration words
  output      logic              word_valid_out,
  output      logic [WORD_W-1:0] word_data_out,
  input  wire logic              word_ready_in
);
  localparam int unsigned EDGES = `PSCL_EDGES_TO_INIT;

  typedef struct packed {
    logic              req_s1;
    logic              req_s2;
    logic              sts_s1;
    logic              sts_s2;
    logic              cd_s1;
    logic              cd_s2;
    logic              clk_s1;
    logic              clk_s2;
    logic              clk_s3;
    logic              dat_s1;
    logic              dat_s2;
    pscl_state_type    st;
    logic [31:0]       cnt;
    logic [31:0]       nbits;
    logic [1:0]        falls;
    logic [WORD_W-1:0] shreg;
    logic [7:0]        sh_cnt;
    logic              init_en;
    logic              push;
    logic              status_oe;
    logic              done_oe;
    logic              init_oe;
    logic              user_oe;
    logic              user_out;
    logic              user_rx;
    logic              user_md;
  } pscl_loader_type;

  pscl_loader_type q, d;
  logic            link_rise;
  logic            link_fall;

  pscl_stream_if #(.WIDTH(WORD_W)) wr_if ();

  ////////////////////////////////////////////////////////////////////
  // Parameters the logic cannot serve
  if (WORD_W < 2 || WORD_W > 255 || BITSTREAM_BITS % WORD_W != 0 ||
      OPT_INIT_BIT >= BITSTREAM_BITS || POR_CYCLES < 1 || STATUS_CYCLES < 1 ||
      INIT_CYCLES < 1) begin : g_bad_param
    $error("pscl_loader: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////
  // Edges of the sampled link clock, from settled stages only
  assign link_rise = q.clk_s2 & ~q.clk_s3;
  assign link_fall = ~q.clk_s2 & q.clk_s3;

  // Word handed to the buffer
  assign wr_if.valid = q.push;
  assign wr_if.data  = q.shreg;

  // Pins from flops; open drain pins only ever pull low
  assign status_n_out              = 1'b0;
  assign status_n_oe_out           = q.status_oe;
  assign load_complete_out         = 1'b0;
  assign load_complete_oe_out      = q.done_oe;
  assign init_done_out             = 1'b0;
  assign init_done_oe_out          = q.init_oe;
  assign config_serial_data_out    = q.user_out;
  assign config_serial_data_oe_out = q.user_oe;
  assign user_rx_out               = q.user_rx;
  assign user_mode_out             = q.user_md;

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    d        = q;
    d.req_s1 = cfg_req_n_in;
    d.req_s2 = q.req_s1;
    d.sts_s1 = status_n_in;
    d.sts_s2 = q.sts_s1;
    d.cd_s1  = load_complete_in;
    d.cd_s2  = q.cd_s1;
    d.clk_s1 = config_serial_clock_in;
    d.clk_s2 = q.clk_s1;
    d.clk_s3 = q.clk_s2;
    d.dat_s1 = config_serial_data_in;
    d.dat_s2 = q.dat_s1;
    d.push   = 1'b0;
    case (q.st)
      PSCL_POR: begin
        // Status low for the whole power-on delay
        d.status_oe = 1'b1;
        d.done_oe   = 1'b1;
        if (q.cnt == 32'(POR_CYCLES - 1)) begin
          d.st  = PSCL_RESET;
          d.cnt = '0;
        end else begin
          d.cnt = q.cnt + 32'h1;
        end
      end
      PSCL_RESET: begin
        // Counting starts only once the request is released
        if (q.cnt == 32'(STATUS_CYCLES - 1)) begin
          d.st        = PSCL_LOAD;
          d.status_oe = 1'b0;
          d.cnt       = '0;
        end else if (q.req_s2) begin
          d.cnt = q.cnt + 32'h1;
        end
      end
      PSCL_LOAD: begin
        // A host holding status low delays the load
        if (link_rise && q.sts_s2) begin
          d.shreg = {q.shreg[WORD_W-2:0], q.dat_s2};
          d.nbits = q.nbits + 32'h1;
          if (q.nbits == 32'(OPT_INIT_BIT)) begin
            d.init_en = q.dat_s2;
          end
          if (q.sh_cnt == 8'(WORD_W - 1)) begin
            d.sh_cnt = '0;
            d.push   = 1'b1;
          end else begin
            d.sh_cnt = q.sh_cnt + 8'h1;
          end
          if (q.nbits == 32'(OPT_INIT_BIT) && q.dat_s2) begin
            d.init_oe = 1'b1;
          end
          if (q.nbits == 32'(BITSTREAM_BITS - 1)) begin
            d.st      = PSCL_WAIT;
            d.done_oe = 1'b0;
            d.falls   = '0;
          end
        end
        // A word lost to a full buffer spoils the load
        if (q.push && !wr_if.ready) begin
          d.st        = PSCL_ERROR;
          d.status_oe = 1'b1;
          d.done_oe   = 1'b1;
        end
      end
      PSCL_WAIT: begin
        // Edges count only once the pin has really gone high
        if (q.push && !wr_if.ready) begin
          d.st        = PSCL_ERROR;
          d.status_oe = 1'b1;
          d.done_oe   = 1'b1;
        end else if (link_fall && q.cd_s2) begin
          if (q.falls == 2'(EDGES - 1)) begin
            d.st  = PSCL_INIT;
            d.cnt = '0;
          end else begin
            d.falls = q.falls + 2'h1;
          end
        end
      end
      PSCL_INIT: begin
        if (q.cnt == 32'(INIT_CYCLES - 1)) begin
          d.st      = PSCL_USER;
          d.init_oe = 1'b0;
          d.user_oe = DATA_PIN_DRIVE;
        end else begin
          d.cnt = q.cnt + 32'h1;
        end
      end
      PSCL_USER: begin
        // Data pin now serves the user design
        d.user_out  = user_tx_in;
        d.user_rx   = q.dat_s2;
        d.status_oe = 1'b0;
        d.done_oe   = 1'b0;
      end
      PSCL_ERROR: begin
        // Held until the host asks again
        d.status_oe = 1'b1;
      end
      default: begin
        d.st = PSCL_RESET;
      end
    endcase
    // Request low aborts anything past power-on
    if (!q.req_s2 && q.st != PSCL_POR) begin
      d.st        = PSCL_RESET;
      d.cnt       = '0;
      d.nbits     = '0;
      d.sh_cnt    = '0;
      d.init_en   = 1'b0;
      d.status_oe = 1'b1;
      d.done_oe   = 1'b1;
      d.init_oe   = 1'b0;
      d.user_oe   = 1'b0;
    end
    // Mode flag registered so the output comes from a flop
    d.user_md = (d.st == PSCL_USER);
  end

  // Register the state; status and load-complete pins start pulled low
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      q           <= '0;
      q.st        <= PSCL_POR;
      q.req_s1    <= 1'b1;
      q.req_s2    <= 1'b1;
      q.status_oe <= 1'b1;
      q.done_oe   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Two-entry buffer; a receiver that lets both entries fill loses the next word
  pscl_word_buf #(.WIDTH(WORD_W)) u_buf (
    .ref_clk_in   (ref_clk_in),
    .rst_n_in     (rst_n_in),
    .wr           (wr_if.snk),
    .rd_valid_out (word_valid_out),
    .rd_data_out  (word_data_out),
    .rd_ready_in  (word_ready_in)
  );

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_user_pins_released : assert property (
    q.st == PSCL_USER |-> !status_n_oe_out && !load_complete_oe_out)
    else $error("status or load-complete pulled low in user mode");
  chk_request_aborts : assert property (
    q.st == PSCL_USER && !q.req_s2 |=> q.st == PSCL_RESET ##1 status_n_oe_out)
    else $error("request did not restart configuration");
  chk_por_status_low : assert property (
    q.st == PSCL_POR |-> status_n_oe_out && q.cnt < 32'(POR_CYCLES))
    else $error("status released during power-on delay");
  chk_done_low_load : assert property (
    q.st inside {PSCL_POR, PSCL_RESET, PSCL_LOAD} |-> load_complete_oe_out)
    else $error("load-complete released before loading ended");
  chk_data_pin_user : assert property (
    config_serial_data_oe_out |-> q.st == PSCL_USER)
    else $error("data pin driven outside user mode");
  chk_done_after_all : assert property (
    $fell(load_complete_oe_out) |-> q.nbits == 32'(BITSTREAM_BITS) && $past(q.st) == PSCL_LOAD)
    else $error("load-complete released before all bits");
  chk_init_pin_low : assert property (
    q.st == PSCL_INIT && q.init_en |-> init_done_oe_out)
    else $error("init pin not held low during initialization");
  chk_bit_capture : assert property (
    q.st == PSCL_LOAD && link_rise && q.sts_s2 && q.req_s2
      |=> q.nbits == $past(q.nbits) + 32'h1 && q.shreg[0] == $past(q.dat_s2))
    else $error("rising edge did not capture one bit");
  chk_two_falls_init : assert property (
    q.st == PSCL_WAIT && q.req_s2 && !(link_fall && q.cd_s2 && q.falls == 2'(EDGES - 1))
      |=> q.st != PSCL_INIT)
    else $error("initialization started before two falls");
endmodule

// ==== rtl/pscl_regs.svh ====
`ifndef PSCL_REGS_SVH
`define PSCL_REGS_SVH
// How it works
// - User mode: request, status, load-complete high
// - Request low abandons user mode, reconfigures
// - Status held low through power-on delay
// - Load-complete low until all data loaded
// - Serial data pin becomes user I/O afterwards
// - Load-complete released at the last bit, pulled low again if the last word is lost
// - Init pin low once option bit loaded as 1

// Core clock rate
`define PSCL_CLK_MHZ        100
// Power-on delay with status held low, in microseconds
`define PSCL_POR_US         268
// Status low time after a configuration request, in microseconds
`define PSCL_STATUS_US      268
// Initialization time before user mode, in microseconds
`define PSCL_INIT_US        175
// Falling edges needed after load-complete
`define PSCL_EDGES_TO_INIT  2
// Default bitstream length and word width
`define PSCL_BITSTREAM_BITS 1024
`define PSCL_WORD_W         8
// Position of the init-pin option bit in the bitstream
`define PSCL_OPT_INIT_BIT   0
// Buffer depth
`define PSCL_BUF_DEPTH      2
`endif

// ==== rtl/pscl_pkg.sv ====
package pscl_pkg;
  // Loader sequence
  typedef enum logic [2:0] {
    PSCL_POR    = 3'b000,
    PSCL_RESET  = 3'b001,
    PSCL_LOAD   = 3'b010,
    PSCL_WAIT   = 3'b011,
    PSCL_INIT   = 3'b100,
    PSCL_USER   = 3'b101,
    PSCL_ERROR  = 3'b110
  } pscl_state_type;
endpackage

// ==== rtl/pscl_stream_if.sv ====
`timescale 1ns/1ns
interface pscl_stream_if #(parameter int unsigned WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/pscl_word_buf.sv ====
`timescale 1ns/1ns
`include "pscl_regs.svh"
module pscl_word_buf
  import pscl_pkg::*;
#(
  parameter int unsigned WIDTH = `PSCL_WORD_W
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  // Filling side
  pscl_stream_if.snk            wr,
  // Draining side
  output      logic             rd_valid_out,
  output      logic [WIDTH-1:0] rd_data_out,
  input  wire logic             rd_ready_in
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wr_ptr;
    logic                  rd_ptr;
    logic [1:0]            count;
    logic                  out_valid;
    logic [WIDTH-1:0]      out_data;
  } pscl_buf_type;

  pscl_buf_type q, d;
  logic         push;
  logic         pop;

  ////////////////////////////////////////////////////////////////////
  // Draining side comes from flops, so no decode reaches the pins
  assign wr.ready     = (q.count != 2'h2);
  assign rd_valid_out = q.out_valid;
  assign rd_data_out  = q.out_data;
  assign push         = wr.valid & wr.ready;
  assign pop          = rd_valid_out & rd_ready_in;

  // Next state
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr_ptr] = wr.data;
      d.wr_ptr        = ~q.wr_ptr;
    end
    if (pop) begin
      d.rd_ptr = ~q.rd_ptr;
    end
    d.count = q.count + {1'b0, push} - {1'b0, pop};
    // Registered copies of the head word and its flag
    d.out_valid = (d.count != 2'h0);
    d.out_data  = d.mem[d.rd_ptr];
  end

  // Register the state
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Never more than two words held
  chk_buf_count_bound : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    q.count <= 2'h2)
    else $error("word buffer count beyond depth");
endmodule

// ==== bench/pscl_host_model.sv ====
`timescale 1ns/1ns
module pscl_host_model (
  // Wire levels seen by the host
  input  wire logic status_n_in,
  input  wire logic load_complete_in,
  // Pins driven by the host
  output      logic cfg_req_n_out,
  output      logic clk_out,
  output      logic data_out,
  output      logic data_oe_out
);
  // Idle pins; clock parked low, never left floating
  initial begin
    cfg_req_n_out = 1'b1;
    clk_out       = 1'b0;
    data_out      = 1'b0;
    data_oe_out   = 1'b0;
  end

  // Request pulse, long enough for the two-flop sync
  task automatic pulse();
    cfg_req_n_out = 1'b0;
    #200;
    cfg_req_n_out = 1'b1;
  endtask

  // No data until the status wire is back high
  task automatic wait_status(output bit ok);
    int n;
    n = 0;
    while (status_n_in !== 1'b1 && n < 2000) begin
      #10;
      n++;
    end
    ok = (status_n_in === 1'b1);
    #100;
  endtask

  // Data changes at the fall, so it is stable well around the rise
  task automatic send(input logic [31:0] bits, input int nbits);
    int n;
    data_oe_out = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      data_out = bits[31-i];
      #63 clk_out = 1'b1;
      #62 clk_out = 1'b0;
    end
    data_oe_out = 1'b0;
    data_out = ~data_out;
    n = 0;
    while (load_complete_in !== 1'b1 && n < 50) begin
      #10;
      n++;
    end
  endtask

  // Extra falling edges after load-complete is released
  task automatic falls(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      #63 clk_out = 1'b1;
      #62 clk_out = 1'b0;
    end
  endtask
endmodule

// ==== bench/test_passive_serial_config_loader.sv ====
`timescale 1ns/1ns
module test_passive_serial_config_loader;
  localparam int unsigned POR  = 20;
  localparam int unsigned STAT = 20;
  localparam int unsigned INIT = 10;
  localparam logic [31:0] PAT  = 32'h81a53c0f;

  logic       ref_clk_in, rst_n_in, word_ready, user_tx, pin_user, init_seen;
  logic       st_o, st_oe, lc_o, lc_oe, id_o, id_oe, d_o, d_oe, rx, um, w_valid;
  logic [7:0] w_data;
  logic       h_req_n, h_clk, h_data, h_oe, ok;
  logic [7:0] got[$];
  wire logic  status_w, lc_w, data_w;
  int         n_fail, comparisons, cycles;

  // Open-drain wires with pull-ups; data pin falls back to the user value
  assign status_w = st_oe ? st_o : 1'b1;
  assign lc_w     = lc_oe ? lc_o : 1'b1;
  assign data_w   = h_oe ? h_data : (d_oe ? d_o : pin_user);

  pscl_loader #(.BITSTREAM_BITS(32), .POR_CYCLES(POR), .STATUS_CYCLES(STAT),
    .INIT_CYCLES(INIT), .DATA_PIN_DRIVE(1'b1)) uut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cfg_req_n_in(h_req_n),
    .status_n_in(status_w), .status_n_out(st_o), .status_n_oe_out(st_oe),
    .load_complete_in(lc_w), .load_complete_out(lc_o), .load_complete_oe_out(lc_oe),
    .init_done_out(id_o), .init_done_oe_out(id_oe),
    .config_serial_clock_in(h_clk), .config_serial_data_in(data_w),
    .config_serial_data_out(d_o), .config_serial_data_oe_out(d_oe),
    .user_tx_in(user_tx), .user_rx_out(rx), .user_mode_out(um),
    .word_valid_out(w_valid), .word_data_out(w_data), .word_ready_in(word_ready));

  pscl_host_model host (.status_n_in(status_w), .load_complete_in(lc_w),
    .cfg_req_n_out(h_req_n), .clk_out(h_clk), .data_out(h_data), .data_oe_out(h_oe));

  // Clock
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Word sink, init-pin monitor and hang guard
  always @(posedge ref_clk_in) begin
    if (w_valid === 1'b1 && word_ready === 1'b1) got.push_back(w_data);
    if (id_oe === 1'b1) init_seen <= 1'b1;
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("Counts: comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Status and load-complete held low through power-on
  task automatic t_power_on();
    settle(POR + STAT - 4);
    check("status_oe", st_oe, 1);
    check("load_oe", lc_oe, 1);
    host.wait_status(ok);
    check("status_up", ok, 1);
  endtask

  // Partial then complete load, two falls, user mode, data pin as user I/O
  task automatic t_load_ok();
    @(posedge ref_clk_in) word_ready <= 1'b1;
    got.delete();
    init_seen = 1'b0;
    host.send(PAT, 31);
    settle(10);
    check("load_oe_part", lc_oe, 1);
    host.send({PAT[0], 31'h0}, 1);
    settle(2);
    check("load_oe_done", lc_oe, 0);
    check("n_words", got.size(), 4);
    for (int i = 0; i < 4; i++) check("word", got[i], PAT[31-8*i -: 8]);
    check("init_seen", init_seen, 1);
    settle(INIT + 20);
    check("um_early", um, 0);
    host.falls(2);
    settle(INIT + 20);
    check("user_mode", um, 1);
    check("status_um", st_oe, 0);
    check("load_um", lc_oe, 0);
    check("init_rel", id_oe, 0);
    check("data_oe", d_oe, 1);
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk_in) user_tx <= v[0];
      settle(6);
      check("user_tx", d_o, v[0]);
      check("user_rx", rx, v[0]);
    end
  endtask

  // Request from user mode starts a new cycle
  task automatic t_reconfig();
    host.pulse();
    settle(2);
    check("um_abort", um, 0);
    check("status_req", st_oe, 1);
    check("load_req", lc_oe, 1);
    host.wait_status(ok);
    check("status_rel", ok, 1);
  endtask

  // Receiver stalls: third word overflows, two stored words survive
  task automatic t_overflow();
    @(posedge ref_clk_in) word_ready <= 1'b0;
    got.delete();
    host.send(PAT, 32);
    settle(5);
    check("err_status", st_oe, 1);
    check("err_load", lc_oe, 1);
    check("full_valid", w_valid, 1);
    @(posedge ref_clk_in) word_ready <= 1'b1;
    settle(5);
    check("drained", got.size(), 2);
    check("w0", got[0], PAT[31:24]);
    check("w1", got[1], PAT[23:16]);
    t_reconfig();
  endtask

  // Main sequence
  initial begin
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    rst_n_in = 1'b0;
    word_ready = 1'b0;
    user_tx = 1'b0;
    pin_user = 1'b1;
    init_seen = 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_power_on();
    t_load_ok();
    t_reconfig();
    t_overflow();
    tally_and_finish();
  end
endmodule
